// ---- pss_pkg.sv ----
// Package for the power source selector logic: constants and carrier types
package pss_pkg;
  // Dead time between switches, in ns, and its cycle count at 100 MHz
  localparam int DEAD_TIME_NS = 150;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEAD_CYCLES = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] DEAD_CNT_INIT = 5'(DEAD_CYCLES);
  // Reset values
  localparam logic SYNC_RST = 1'b0;
  localparam logic GATE_OFF_RST = 1'b1;
  localparam logic [3:0] INT_RST = 4'h0;
  // Register offsets
  localparam logic [3:0] OFF_STATUS = 4'h0;
  localparam logic [3:0] OFF_CLEAR = 4'h4;
  localparam logic [3:0] OFF_ENABLE = 4'h8;
  localparam logic [3:0] OFF_STATE = 4'hC;
  // Interrupt bit positions
  localparam int IRQ_DEPLETED = 0;
  localparam int IRQ_DEEP = 1;
  localparam int IRQ_ADP_LOST = 2;
  localparam int IRQ_SWITCHED = 3;

  // Selected source
  typedef enum logic [1:0] {
    PSS_SRC_BATTERY,
    PSS_SRC_DEAD_TO_ADP,
    PSS_SRC_DEAD_TO_BAT,
    PSS_SRC_ADAPTER
  } pss_src_e;

  // Synchronised comparator and request inputs
  typedef struct packed {
    logic adapter_ok;
    logic below_depletion;
    logic below_deep;
    logic select_req;
  } pss_sense_s;

  // Gate commands, high means switch off (P-channel)
  typedef struct packed {
    logic adapter_gate_cmd;
    logic battery_gate_cmd;
  } pss_gate_s;
endpackage

// ---- pss_selector.sv ----
// Power source selector with depletion flag, dead time and interrupt registers
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Overview of the selector, for whoever picks this block up next.
// Three comparator results and the host request arrive as plain levels from
// outside the clock domain. Each passes two flops before any decision reads
// it, so a level that changes near an edge cannot split the decision logic.
// The variant strap is handled the same way, even though it is meant to be
// static, because a board can still tie it to a slow-moving signal.
// The source wish is a pure function of the synchronised levels:
//   adapter wanted = adapter present and (host request or revert on deep).
// Loss of the adapter always wins, whatever the host asks for.
// Depletion alone never moves power in either variant; only deep discharge
// in the revert variant, or the host itself, can do that.
// The sequencer has two settled states and two dead states. Entering a dead
// state turns both switches off at once; only when the dead counter has run
// down does the new switch turn on. A reversal during a dead state goes to
// the other dead state and restarts the count, so the dead time is always
// served in full before any switch closes again.
// Gate commands are active high off, matching P-channel switches: a high
// command means the switch is open. After reset both commands are high and
// the sequencer parks on battery through a full dead time, which costs a
// little start-up time but never closes both switches together.
// Charging is suspended unless the adapter is the settled source; the dead
// states count as battery for this purpose, trading a few cycles of lost
// charge for never charging while the source is uncertain.
// The battery-low flag and the presence report are registered copies of
// the synchronised levels, three edges behind the pins.
// Four sticky status bits record depletion rise, deep rise, adapter loss
// and completion of a switch. A write of ones to the clear offset clears
// them, but an event in that same cycle is kept, so no event is lost.
// The enable register masks which status bits drive the level interrupt.
// Reads answer in the cycle after the strobe and return zero otherwise,
// which lets a simple host OR several slaves' read data together.
// Limitation: the dead time is a fixed count of clock cycles, not a
// measurement of the gate voltages; a slow gate needs a longer count.
module pss_selector (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic revert_variant,
  input wire logic adapter_detect_in,
  input wire logic depletion_threshold_input,
  input wire logic deep_discharge_in,
  input wire logic source_select_request,
  output logic battery_low_flag,
  output logic adapter_present_out,
  output logic adapter_gate_cmd,
  output logic battery_gate_cmd,
  output logic charge_suspend,
  output logic irq,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  pss_pkg::pss_sense_s meta_r;
  pss_pkg::pss_sense_s sense_r;
  pss_pkg::pss_sense_s sense_prev_r;
  pss_pkg::pss_src_e src_r;
  pss_pkg::pss_src_e src_nxt;
  pss_pkg::pss_gate_s gate_r;
  pss_pkg::pss_gate_s gate_nxt;
  logic [4:0] dead_cnt_r;
  logic want_adapter;
  logic revert_meta_r;
  logic revert_r;
  logic [3:0] status_r;
  logic [3:0] enable_r;
  logic [3:0] events;
  logic [31:0] rdata_r;

  // Rising edge of a synchronised level, used by several event bits
  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction

  // Two-stage synchroniser; only stage two is read by logic
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_r <= '0;
      sense_r <= '0;
    end else begin
      meta_r <= '{adapter_ok: adapter_detect_in, below_depletion: depletion_threshold_input,
                  below_deep: deep_discharge_in, select_req: source_select_request};
      sense_r <= meta_r;
    end
  end

  // Variant strap through two flops like any other pin
  always_ff @(posedge core_clk) begin
    if (rst) begin
      revert_meta_r <= 1'b0;
      revert_r <= 1'b0;
    end else begin
      revert_meta_r <= revert_variant;
      revert_r <= revert_meta_r;
    end
  end

  // Previous sensed values for event edges
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sense_prev_r <= '0;
    end else begin
      sense_prev_r <= sense_r;
    end
  end

  // Source wish: request and presence, plus deep-discharge override in revert variant
  always_comb begin
    want_adapter = sense_r.adapter_ok & sense_r.select_req;
    if (revert_r && sense_r.below_deep && sense_r.adapter_ok) begin
      want_adapter = 1'b1;
    end
    // Hold variant: depletion alone never forces a change
    if (!sense_r.adapter_ok) begin
      want_adapter = 1'b0;
    end
  end

  // Selection sequencer with dead time; both gates high while switching
  always_comb begin
    src_nxt = src_r;
    gate_nxt = gate_r;
    unique case (src_r)
      // Settled on battery: adapter off, battery on
      pss_pkg::PSS_SRC_BATTERY: begin
        gate_nxt = '{adapter_gate_cmd: 1'b1, battery_gate_cmd: 1'b0};
        if (want_adapter) begin
          src_nxt = pss_pkg::PSS_SRC_DEAD_TO_ADP;
          gate_nxt = '{adapter_gate_cmd: 1'b1, battery_gate_cmd: 1'b1};
        end
      end
      // Both off, counting down before the adapter closes
      pss_pkg::PSS_SRC_DEAD_TO_ADP: begin
        gate_nxt = '{adapter_gate_cmd: 1'b1, battery_gate_cmd: 1'b1};
        if (!want_adapter) begin
          src_nxt = pss_pkg::PSS_SRC_DEAD_TO_BAT;
        end else if (dead_cnt_r == 5'h00) begin
          src_nxt = pss_pkg::PSS_SRC_ADAPTER;
          gate_nxt = '{adapter_gate_cmd: 1'b0, battery_gate_cmd: 1'b1};
        end
      end
      // Both off, counting down before the battery closes
      pss_pkg::PSS_SRC_DEAD_TO_BAT: begin
        gate_nxt = '{adapter_gate_cmd: 1'b1, battery_gate_cmd: 1'b1};
        if (want_adapter) begin
          src_nxt = pss_pkg::PSS_SRC_DEAD_TO_ADP;
        end else if (dead_cnt_r == 5'h00) begin
          src_nxt = pss_pkg::PSS_SRC_BATTERY;
          gate_nxt = '{adapter_gate_cmd: 1'b1, battery_gate_cmd: 1'b0};
        end
      end
      // Settled on adapter: battery off, adapter on
      pss_pkg::PSS_SRC_ADAPTER: begin
        gate_nxt = '{adapter_gate_cmd: 1'b0, battery_gate_cmd: 1'b1};
        if (!want_adapter) begin
          src_nxt = pss_pkg::PSS_SRC_DEAD_TO_BAT;
          gate_nxt = '{adapter_gate_cmd: 1'b1, battery_gate_cmd: 1'b1};
        end
      end
    endcase
  end

  // Source state and gate registers; reset parks on battery via dead time
  always_ff @(posedge core_clk) begin
    if (rst) begin
      src_r <= pss_pkg::PSS_SRC_DEAD_TO_BAT;
      gate_r <= '{adapter_gate_cmd: pss_pkg::GATE_OFF_RST, battery_gate_cmd: pss_pkg::GATE_OFF_RST};
    end else begin
      src_r <= src_nxt;
      gate_r <= gate_nxt;
    end
  end

  // Dead-time counter, reloaded on entry to a dead state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dead_cnt_r <= pss_pkg::DEAD_CNT_INIT;
    end else if (src_nxt != src_r) begin
      dead_cnt_r <= pss_pkg::DEAD_CNT_INIT;
    end else if (dead_cnt_r != 5'h00) begin
      dead_cnt_r <= dead_cnt_r - 5'h01;
    end
  end

  // Status outputs from flip-flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      battery_low_flag <= 1'b0;
      adapter_present_out <= 1'b0;
      charge_suspend <= 1'b1;
    end else begin
      battery_low_flag <= sense_r.below_depletion;
      adapter_present_out <= sense_r.adapter_ok;
      charge_suspend <= (src_nxt != pss_pkg::PSS_SRC_ADAPTER);
    end
  end

  assign adapter_gate_cmd = gate_r.adapter_gate_cmd;
  assign battery_gate_cmd = gate_r.battery_gate_cmd;

  // Events: rising depletion, rising deep, adapter loss, entry to a settled source
  assign events[pss_pkg::IRQ_DEPLETED] = rise(sense_r.below_depletion, sense_prev_r.below_depletion);
  assign events[pss_pkg::IRQ_DEEP] = rise(sense_r.below_deep, sense_prev_r.below_deep);
  // Loss is a rise of the inverted presence level
  assign events[pss_pkg::IRQ_ADP_LOST] = rise(~sense_r.adapter_ok, ~sense_prev_r.adapter_ok);
  assign events[pss_pkg::IRQ_SWITCHED] = (src_nxt != src_r) &&
      (src_nxt == pss_pkg::PSS_SRC_ADAPTER || src_nxt == pss_pkg::PSS_SRC_BATTERY);

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_r <= pss_pkg::INT_RST;
    end else if (reg_wr && reg_addr == pss_pkg::OFF_CLEAR) begin
      status_r <= (status_r & ~reg_wdata[3:0]) | events;
    end else begin
      status_r <= status_r | events;
    end
  end

  // Interrupt enable register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      enable_r <= pss_pkg::INT_RST;
    end else if (reg_wr && reg_addr == pss_pkg::OFF_ENABLE) begin
      enable_r <= reg_wdata[3:0];
    end
  end

  assign irq = |(status_r & enable_r);

  // Read data one cycle after the strobe, zero otherwise and for unmapped
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        pss_pkg::OFF_STATUS: rdata_r <= {28'h000_0000, status_r};
        pss_pkg::OFF_ENABLE: rdata_r <= {28'h000_0000, enable_r};
        pss_pkg::OFF_STATE: rdata_r <= {24'h00_0000, sense_r, revert_r, charge_suspend, src_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_r;
endmodule
`default_nettype wire

// ---- pss_selector_props.sv ----
// Checker for the power source selector ports
`timescale 1ns/1ps
`default_nettype none
module pss_selector_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic adapter_detect_in,
  input wire logic depletion_threshold_input,
  input wire logic battery_low_flag,
  input wire logic adapter_present_out,
  input wire logic adapter_gate_cmd,
  input wire logic battery_gate_cmd,
  input wire logic charge_suspend,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  logic [4:0] off_r = 5'h0;
  logic [2:0] up_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Both-off run length; counts through reset so the first switch is judged too
  always_ff @(posedge core_clk) begin
    off_r <= (adapter_gate_cmd & battery_gate_cmd) ? off_r + 5'(~&off_r) : 5'h0;
  end
  // Cycles since reset, so the sync pipe holds no reset values
  always_ff @(posedge core_clk) begin
    up_r <= rst ? 3'h0 : up_r + 3'(up_r != 3'h4);
  end
  AST_NO_OVERLAP: assert property (adapter_gate_cmd | battery_gate_cmd)
    else $error("both switches on");
  AST_DEAD_TIME: assert property (($fell(adapter_gate_cmd) || $fell(battery_gate_cmd))
    |-> $past(off_r) >= 5'hE) else $error("dead time short");
  AST_FLAG_TRACK: assert property (up_r == 3'h4
    |-> battery_low_flag == $past(depletion_threshold_input, 3)) else $error("flag wrong");
  AST_PRES_TRACK: assert property (up_r == 3'h4
    |-> adapter_present_out == $past(adapter_detect_in, 3)) else $error("presence wrong");
  AST_SUSPEND: assert property (!battery_gate_cmd && !$past(battery_gate_cmd)
    |-> charge_suspend) else $error("charging on battery");
  AST_LOSS: assert property ($fell(adapter_present_out)
    |-> ##[0:1] adapter_gate_cmd ##[14:18] !battery_gate_cmd) else $error("no switch on loss");
  AST_WALL_NEEDS_ADP: assert property (!adapter_gate_cmd |-> $past(adapter_present_out))
    else $error("wall without adapter");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside slot");
endmodule
bind pss_selector pss_selector_props i_props (.*);
`default_nettype wire

// ---- pss_host_model.sv ----
// Host controller model driving the source select request
`timescale 1ns/1ps
`default_nettype none
module pss_host_model (
  input wire logic react_en,
  input wire logic want_wall,
  input wire logic battery_low_flag,
  output logic source_select_request
);
  // Host asks for wall power on a low battery only when told to react
  assign source_select_request = want_wall | (react_en & battery_low_flag);
endmodule
`default_nettype wire

// ---- test_power_source_selector_logic.sv ----
// Testbench for the power source selector
`timescale 1ns/1ps
`default_nettype none
module test_power_source_selector_logic;
  logic core_clk = 1'b0, rst = 1'b1, revert_variant = 1'b0, adapter_detect_in = 1'b0;
  logic depletion_threshold_input = 1'b0, deep_discharge_in = 1'b0;
  logic want_wall = 1'b0, react_en = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic source_select_request, battery_low_flag, adapter_present_out, adapter_gate_cmd;
  logic battery_gate_cmd, charge_suspend, irq;
  logic [31:0] reg_rdata, rdv;
  int mismatches = 0, samples_checked = 0;
  always #5 core_clk = ~core_clk;
  pss_selector i_dut (.*);
  pss_host_model i_host (.*);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Inputs {adp,want,dep,deep,revert,react}; expects {present,flag,gates,suspend}
  task automatic step(input logic [5:0] v, input logic [2:0] s);
    @(posedge core_clk);
    {adapter_detect_in, want_wall, depletion_threshold_input} <= v[5:3];
    {deep_discharge_in, revert_variant, react_en} <= v[2:0];
    tick(30);
    chk(32'({adapter_present_out, battery_low_flag, adapter_gate_cmd, battery_gate_cmd,
      charge_suspend}), 32'({v[5], v[3], s}));
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
  endtask
  task automatic t_select;
    step(6'b000000, 3'h5);
    step(6'b100000, 3'h5);
    step(6'b110000, 3'h2);
  endtask
  // Depletion must not move power; only the host may
  task automatic t_hold;
    step(6'b111000, 3'h2);
    step(6'b100000, 3'h5);
    step(6'b101000, 3'h5);
    step(6'b101001, 3'h2);
    step(6'b100100, 3'h5);
  endtask
  task automatic t_loss;
    step(6'b110000, 3'h2);
    step(6'b010000, 3'h5);
    step(6'b110000, 3'h2);
  endtask
  task automatic t_revert;
    step(6'b100010, 3'h5);
    step(6'b101110, 3'h2);
    step(6'b001110, 3'h5);
    step(6'b000000, 3'h5);
  endtask
  task automatic t_regs;
    wr_reg(pss_pkg::OFF_CLEAR, 32'hF);
    wr_reg(pss_pkg::OFF_ENABLE, 32'h1);
    rd_reg(pss_pkg::OFF_ENABLE);
    chk(rdv, 32'h1);
    chk(32'(irq), 32'h0);
    step(6'b001000, 3'h5);
    chk(32'(irq), 32'h1);
    rd_reg(pss_pkg::OFF_STATUS);
    chk(rdv, 32'h1);
    wr_reg(pss_pkg::OFF_CLEAR, 32'h1);
    tick(1);
    chk(32'(irq), 32'h0);
    wr_reg(pss_pkg::OFF_ENABLE, 32'h0);
    step(6'b000000, 3'h5);
    step(6'b001000, 3'h5);
    chk(32'(irq), 32'h0);
    rd_reg(4'h2);
    chk(rdv, 32'h0);
  endtask
  // Switch, loss and deep events plus the state register
  task automatic t_status;
    wr_reg(pss_pkg::OFF_CLEAR, 32'hF);
    step(6'b110000, 3'h2);
    rd_reg(pss_pkg::OFF_STATUS);
    chk(rdv, 32'h8);
    rd_reg(pss_pkg::OFF_STATE);
    chk(rdv, 32'h93);
    wr_reg(pss_pkg::OFF_CLEAR, 32'hF);
    step(6'b010100, 3'h5);
    rd_reg(pss_pkg::OFF_STATUS);
    chk(rdv, 32'hE);
    rd_reg(pss_pkg::OFF_STATE);
    chk(rdv, 32'h34);
    wr_reg(pss_pkg::OFF_ENABLE, 32'h4);
    tick(1);
    chk(32'(irq), 32'h1);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Main sequence after four reset cycles
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_select();
    t_hold();
    t_loss();
    t_revert();
    t_regs();
    t_status();
    final_report();
  end
  // Watchdog, about four times the expected run
  initial begin
    #25000;
    mismatches++;
    final_report();
  end
endmodule
`default_nettype wire
